// [saio_pkg.sv]
/*
  Shared constants and types for the sensor front-end digital control block.
  Assumes a single 10 MHz master clock and a synchronous, active-high reset.
*/
package saio_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int OSC_HZ = 4_000_000;
  localparam int SCL_MAX_HZ = 400_000;
  // fewest master clocks in one serial clock period at the fastest bus rate
  localparam int SCL_MIN_CYC = CLK_HZ / SCL_MAX_HZ;
  // register indices reached over the two-wire port
  localparam logic [7:0] REG_OUT_A = 8'h40;
  localparam logic [7:0] REG_IN_A = 8'h41;
  localparam logic [7:0] REG_MODE_A = 8'h42;
  // reset values and writable masks
  localparam logic [7:0] OUT_RST = 8'h30;
  localparam logic [7:0] OUT_MASK = 8'h33;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] MODE_MASK = 8'h0F;
  // field positions
  localparam int DATA_LSB = 0;
  localparam int DIR_LSB = 4;
  localparam int REFOUT_BIT = 0;
  localparam int REFIN_BIT = 1;
  localparam int FOFF_BIT = 2;
  localparam int FON_BIT = 3;
  // slave addressing
  localparam logic [6:0] ADDR_BASE = 7'h48;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET = 8'h06;
  // cycle counts
  localparam logic [15:0] BOOT_CYC = 16'h0020;
  localparam logic [15:0] STRETCH_CYC = 16'h0002;
  localparam int SMP_DIV_DEF = 8;

  typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_RX, ST_STRETCH, ST_ACK, ST_TX, ST_TXACK} saio_st_e;
  typedef enum logic [1:0] {K_ADDR, K_REG, K_DATA, K_GC} saio_kind_e;
endpackage

// [saio_reg_if.sv]
/*
  Carrier between the two-wire engine and the register bank.
  Assumes both ends run on the same master clock.
*/
`timescale 1ns/1ps
interface saio_reg_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  logic softRst;
  logic [1:0] pinLevel;
  logic [1:0] dir;
  logic [1:0] data;
  logic refOut;
  logic refIn;
  logic forceOff;
  logic forceOn;
  modport bus (output addr, wdata, wr, rd, softRst, pinLevel,
    input rdata, dir, data, refOut, refIn, forceOff, forceOn);
  modport regs (input addr, wdata, wr, rd, softRst, pinLevel,
    output rdata, dir, data, refOut, refIn, forceOff, forceOn);
endinterface

// [saio_regs.sv]
/*
  Register bank: port output/direction, port input levels and mode bits.
  Assumes single-cycle read and write strobes from the two-wire engine.
*/
`timescale 1ns/1ps
module saio_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // access from the serial engine
  saio_reg_if.regs rb
);
  logic [7:0] outQ_ff;
  logic [7:0] nxt_outQ;
  logic [7:0] modeQ_ff;
  logic [7:0] nxt_modeQ;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_outQ = outQ_ff;
    nxt_modeQ = modeQ_ff;
    nxt_rdata = rdata_ff;
    if (rb.softRst) begin
      nxt_outQ = saio_pkg::OUT_RST;
      nxt_modeQ = saio_pkg::MODE_RST;
    end else if (rb.wr) begin
      // the input register is read only; writes to it are dropped
      if (rb.addr == saio_pkg::REG_OUT_A) begin
        nxt_outQ = rb.wdata & saio_pkg::OUT_MASK;
      end else if (rb.addr == saio_pkg::REG_MODE_A) begin
        nxt_modeQ = rb.wdata & saio_pkg::MODE_MASK;
      end
    end
    if (rb.rd) begin
      if (rb.addr == saio_pkg::REG_OUT_A) begin
        nxt_rdata = outQ_ff;
      end else if (rb.addr == saio_pkg::REG_IN_A) begin
        nxt_rdata = {6'h00, rb.pinLevel};
      end else if (rb.addr == saio_pkg::REG_MODE_A) begin
        nxt_rdata = modeQ_ff;
      end else begin
        nxt_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      outQ_ff <= saio_pkg::OUT_RST;
      modeQ_ff <= saio_pkg::MODE_RST;
      rdata_ff <= 8'h00;
    end else begin
      outQ_ff <= nxt_outQ;
      modeQ_ff <= nxt_modeQ;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rb.rdata = rdata_ff;
  assign rb.dir = outQ_ff[saio_pkg::DIR_LSB +: 2];
  assign rb.data = outQ_ff[saio_pkg::DATA_LSB +: 2];
  assign rb.refOut = modeQ_ff[saio_pkg::REFOUT_BIT];
  assign rb.refIn = modeQ_ff[saio_pkg::REFIN_BIT];
  assign rb.forceOff = modeQ_ff[saio_pkg::FOFF_BIT];
  assign rb.forceOn = modeQ_ff[saio_pkg::FON_BIT];
endmodule

// [saio_top.sv]
/*
  Digital control of the sensor front end: two-pin port, charge pump control,
  oscillator boot/sleep, end-of-conversion pulse and two-wire slave port.
  Assumes open-drain bus pins resolved outside, analog comparator levels
  arriving asynchronously, and a conversion-done strobe on mclk.
*/
`timescale 1ns/1ps
module saio_top #(
  parameter int SMP_DIV = saio_pkg::SMP_DIV_DEF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // two-wire bus, open drain
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // port pins
  input wire logic [1:0] pinIn,
  output logic [1:0] pinOut,
  output logic [1:0] pinOe,
  output logic refOutEn,
  output logic refInEn,
  // charge pump
  input wire logic battLow,
  input wire logic pumpAtLevel,
  output logic pumpEnable,
  output logic pumpBypass,
  output logic pumpReady,
  // oscillator and address strap
  input wire logic [2:0] addrSel,
  output logic oscEnable,
  // conversion timing
  input wire logic convDone,
  output logic sampleTick,
  output logic readyN
);
  saio_reg_if rb ();

  saio_regs u_regs (
    .mclk(mclk),
    .rst(rst),
    .rb(rb)
  );

  // synchronisers: first stage feeds only the second
  logic [5:0] syA_ff;
  logic [5:0] syB_ff;
  logic sclD_ff;
  logic sdaD_ff;
  logic sclS;
  logic sdaS;
  logic [1:0] pinS;
  logic battLowS;
  logic pumpOkS;

  always_ff @(posedge mclk) begin
    if (rst) begin
      syA_ff <= 6'h30;
      syB_ff <= 6'h30;
      sclD_ff <= 1'b1;
      sdaD_ff <= 1'b1;
    end else begin
      syA_ff <= {sclIn, sdaIn, pinIn, battLow, pumpAtLevel};
      syB_ff <= syA_ff;
      sclD_ff <= sclS;
      sdaD_ff <= sdaS;
    end
  end

  assign sclS = syB_ff[5];
  assign sdaS = syB_ff[4];
  assign pinS = syB_ff[3:2];
  assign battLowS = syB_ff[1];
  assign pumpOkS = syB_ff[0];

  logic sclRise;
  logic sclFall;
  logic startEv;
  logic stopEv;
  assign sclRise = sclS & ~sclD_ff;
  assign sclFall = ~sclS & sclD_ff;
  assign startEv = sclS & sclD_ff & sdaD_ff & ~sdaS;
  assign stopEv = sclS & sclD_ff & ~sdaD_ff & sdaS;

  // serial engine state
  saio_pkg::saio_st_e state_ff;
  saio_pkg::saio_st_e nxt_state;
  saio_pkg::saio_kind_e kind_ff;
  saio_pkg::saio_kind_e nxt_kind;
  logic [3:0] bitCnt_ff;
  logic [3:0] nxt_bitCnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [7:0] txSh_ff;
  logic [7:0] nxt_txSh;
  logic [7:0] regAddr_ff;
  logic [7:0] nxt_regAddr;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [6:0] myAddr_ff;
  logic [6:0] nxt_myAddr;
  logic rdMode_ff;
  logic nxt_rdMode;
  logic ackDrv_ff;
  logic nxt_ackDrv;
  logic mAck_ff;
  logic nxt_mAck;
  logic busWr;
  logic busRd;
  logic busGc;

  always_comb begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_shift = shift_ff;
    nxt_txSh = txSh_ff;
    nxt_regAddr = regAddr_ff;
    nxt_cnt = cnt_ff;
    nxt_myAddr = myAddr_ff;
    nxt_rdMode = rdMode_ff;
    nxt_ackDrv = ackDrv_ff;
    nxt_mAck = mAck_ff;
    busWr = 1'b0;
    busRd = 1'b0;
    busGc = 1'b0;
    unique case (state_ff)
      saio_pkg::ST_BOOT: begin
        // settings load window; the strap is caught once, well after release
        nxt_cnt = cnt_ff + 16'h0001;
        if (cnt_ff == saio_pkg::BOOT_CYC - 16'h0001) begin
          nxt_myAddr = saio_pkg::ADDR_BASE | {4'h0, addrSel};
          nxt_state = saio_pkg::ST_IDLE;
        end
      end
      saio_pkg::ST_IDLE: begin
      end
      saio_pkg::ST_RX: begin
        if (sclRise) begin
          nxt_shift = {shift_ff[6:0], sdaS};
          nxt_bitCnt = bitCnt_ff + 4'h1;
        end else if (sclFall && bitCnt_ff == 4'h8) begin
          nxt_ackDrv = 1'b1;
          nxt_cnt = 16'h0000;
          nxt_state = saio_pkg::ST_STRETCH;
          unique case (kind_ff)
            saio_pkg::K_ADDR: begin
              if (shift_ff[7:1] == myAddr_ff) begin
                nxt_rdMode = shift_ff[0];
                nxt_kind = saio_pkg::K_REG;
                busRd = shift_ff[0];
                nxt_regAddr = shift_ff[0] ? regAddr_ff + 8'h01 : regAddr_ff;
              end else if (shift_ff == saio_pkg::GC_ADDR) begin
                nxt_kind = saio_pkg::K_GC;
              end else begin
                nxt_ackDrv = 1'b0;
              end
            end
            saio_pkg::K_REG: begin
              nxt_regAddr = shift_ff;
              nxt_kind = saio_pkg::K_DATA;
            end
            saio_pkg::K_DATA: begin
              busWr = 1'b1;
              nxt_regAddr = regAddr_ff + 8'h01;
            end
            saio_pkg::K_GC: begin
              busGc = (shift_ff == saio_pkg::GC_RESET);
            end
          endcase
        end
      end
      saio_pkg::ST_STRETCH: begin
        // clock held low only here, right before the acknowledge bit
        nxt_cnt = cnt_ff + 16'h0001;
        if (cnt_ff == saio_pkg::STRETCH_CYC - 16'h0001) begin
          nxt_state = saio_pkg::ST_ACK;
        end
      end
      saio_pkg::ST_ACK: begin
        if (sclFall) begin
          nxt_ackDrv = 1'b0;
          nxt_bitCnt = 4'h0;
          if (!ackDrv_ff) begin
            nxt_state = saio_pkg::ST_IDLE;
          end else if (rdMode_ff) begin
            nxt_txSh = rb.rdata;
            nxt_state = saio_pkg::ST_TX;
          end else begin
            nxt_state = saio_pkg::ST_RX;
          end
        end
      end
      saio_pkg::ST_TX: begin
        if (sclFall) begin
          if (bitCnt_ff == 4'h7) begin
            nxt_bitCnt = 4'h0;
            nxt_state = saio_pkg::ST_TXACK;
          end else begin
            nxt_txSh = {txSh_ff[6:0], 1'b0};
            nxt_bitCnt = bitCnt_ff + 4'h1;
          end
        end
      end
      saio_pkg::ST_TXACK: begin
        // master acknowledges; no stretching here, data is fetched meanwhile
        if (sclRise) begin
          nxt_mAck = ~sdaS;
          busRd = ~sdaS;
          nxt_regAddr = sdaS ? regAddr_ff : regAddr_ff + 8'h01;
        end else if (sclFall) begin
          if (mAck_ff) begin
            nxt_txSh = rb.rdata;
            nxt_state = saio_pkg::ST_TX;
          end else begin
            nxt_state = saio_pkg::ST_IDLE;
          end
        end
      end
    endcase
    // bus conditions override any byte in progress once booted
    if (state_ff != saio_pkg::ST_BOOT) begin
      if (startEv) begin
        nxt_state = saio_pkg::ST_RX;
        nxt_kind = saio_pkg::K_ADDR;
        nxt_bitCnt = 4'h0;
        nxt_rdMode = 1'b0;
        nxt_ackDrv = 1'b0;
      end else if (stopEv) begin
        nxt_state = saio_pkg::ST_IDLE;
        nxt_ackDrv = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= saio_pkg::ST_BOOT;
      kind_ff <= saio_pkg::K_ADDR;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      txSh_ff <= 8'h00;
      regAddr_ff <= 8'h00;
      cnt_ff <= 16'h0000;
      myAddr_ff <= saio_pkg::ADDR_BASE;
      rdMode_ff <= 1'b0;
      ackDrv_ff <= 1'b0;
      mAck_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      bitCnt_ff <= nxt_bitCnt;
      shift_ff <= nxt_shift;
      txSh_ff <= nxt_txSh;
      regAddr_ff <= nxt_regAddr;
      cnt_ff <= nxt_cnt;
      myAddr_ff <= nxt_myAddr;
      rdMode_ff <= nxt_rdMode;
      ackDrv_ff <= nxt_ackDrv;
      mAck_ff <= nxt_mAck;
    end
  end

  assign rb.addr = regAddr_ff;
  assign rb.wdata = shift_ff;
  assign rb.wr = busWr;
  assign rb.rd = busRd;
  assign rb.softRst = busGc;
  assign rb.pinLevel = pinS;

  // open-drain bus: only the enables toggle
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = (state_ff == saio_pkg::ST_STRETCH);
  assign sdaOe = ((state_ff == saio_pkg::ST_STRETCH || state_ff == saio_pkg::ST_ACK) && ackDrv_ff)
    || (state_ff == saio_pkg::ST_TX && !txSh_ff[7]);
  assign oscEnable = (state_ff != saio_pkg::ST_IDLE);

  // port pins; reference mode takes the pin away from the digital driver
  assign pinOut = rb.data;
  assign pinOe[0] = rb.dir[0] & ~rb.refOut;
  assign pinOe[1] = rb.dir[1] & ~rb.refIn;
  assign refOutEn = rb.refOut;
  assign refInEn = rb.refIn;

  // pump control: force-on wins, force-off pins the bypass
  assign pumpEnable = rb.forceOn | (~rb.forceOff & battLowS);
  assign pumpBypass = ~pumpEnable;
  assign pumpReady = pumpOkS;

  // sample-rate enable and end-of-conversion pulse
  logic [7:0] divCnt_ff;
  logic [7:0] nxt_divCnt;
  logic [7:0] rdyCnt_ff;
  logic [7:0] nxt_rdyCnt;
  logic tick_ff;
  logic nxt_tick;
  logic readyN_ff;
  logic nxt_readyN;

  always_comb begin
    nxt_tick = (divCnt_ff == 8'(SMP_DIV - 1));
    nxt_divCnt = nxt_tick ? 8'h00 : divCnt_ff + 8'h01;
    nxt_rdyCnt = rdyCnt_ff;
    if (convDone && rdyCnt_ff == 8'h00) begin
      nxt_rdyCnt = 8'(SMP_DIV);
    end else if (rdyCnt_ff != 8'h00) begin
      nxt_rdyCnt = rdyCnt_ff - 8'h01;
    end
    nxt_readyN = (nxt_rdyCnt == 8'h00);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      divCnt_ff <= 8'h00;
      rdyCnt_ff <= 8'h00;
      tick_ff <= 1'b0;
      readyN_ff <= 1'b1;
    end else begin
      divCnt_ff <= nxt_divCnt;
      rdyCnt_ff <= nxt_rdyCnt;
      tick_ff <= nxt_tick;
      readyN_ff <= nxt_readyN;
    end
  end

  assign sampleTick = tick_ff;
  assign readyN = readyN_ff;

  // assertion helpers
  logic [7:0] lowCnt_ff;
  always_ff @(posedge mclk) begin
    if (rst || readyN_ff) begin
      lowCnt_ff <= 8'h00;
    end else begin
      lowCnt_ff <= lowCnt_ff + 8'h01;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_dir_tristate: assert property ((pinOe & ~rb.dir) == 2'b00)
    else $error("pin driven with direction bit clear");
  a_reset_dir: assert property ($past(rst) |-> rb.dir == 2'b11 && pinOut == 2'b00)
    else $error("port defaults wrong after reset");
  a_drive_data: assert property (busWr && regAddr_ff == saio_pkg::REG_OUT_A
    |=> pinOut == $past(shift_ff[1:0]))
    else $error("driven pin level not from data bit");
  a_ref_bypass: assert property (rb.refOut && rb.refIn |-> pinOe == 2'b00)
    else $error("pin driven while in reference mode");
  a_force_on: assert property (rb.forceOn |-> pumpEnable && !pumpBypass)
    else $error("force-on not keeping pump on");
  a_force_off: assert property (rb.forceOff && !rb.forceOn |-> pumpBypass && !pumpEnable)
    else $error("force-off not bypassing pump");
  a_auto_pump: assert property (!rb.forceOn && !rb.forceOff |-> pumpEnable == $past(battLow, 2))
    else $error("auto pump not following battery comparator");
  a_pump_ready: assert property ($rose(pumpReady) |-> $past(pumpAtLevel, 2))
    else $error("pump ready without level");
  a_ready_pulse: assert property ($rose(readyN) |-> lowCnt_ff == 8'(SMP_DIV))
    else $error("ready pulse length wrong");
  a_stretch_ack: assert property ($rose(sclOe) |-> $past(state_ff) == saio_pkg::ST_RX ##2 !sclOe)
    else $error("clock stretch outside acknowledge slot");
  a_addr_match: assert property (state_ff == saio_pkg::ST_RX && kind_ff == saio_pkg::K_ADDR
    && sclFall && bitCnt_ff == 4'h8 && shift_ff[7:1] == myAddr_ff && !startEv && !stopEv
    |=> ackDrv_ff)
    else $error("own address not acknowledged");
  a_gc_reset: assert property (busGc |=> rb.dir == 2'b11 && !rb.forceOn && !rb.refOut)
    else $error("general call reset ignored");
  a_input_read: assert property (busRd && regAddr_ff == saio_pkg::REG_IN_A
    |=> rb.rdata == {6'h00, $past(pinS)})
    else $error("input register not showing pin levels");
  a_sleep_osc: assert property (stopEv && state_ff != saio_pkg::ST_BOOT |=> !oscEnable)
    else $error("oscillator left running after stop");

  c_write: cover property (busWr);
  c_read: cover property (state_ff == saio_pkg::ST_TX && rdMode_ff);
  c_gcall: cover property (busGc);
  c_ready: cover property ($rose(readyN));
endmodule

// [saio_host.sv]
/*
  Host controller model: two-wire bus master issuing register transfers.
  Assumes open-drain wires with pull-ups resolved in the bench.
*/
`timescale 1ns/1ps
module saio_host #(
  parameter int Q = 8
) (
  // clock
  input wire logic mclk,
  // resolved wires and pull-down enables
  input wire logic scl,
  input wire logic sda,
  output logic sclOe,
  output logic sdaOe
);
  initial begin
    sclOe = 1'b0;
    sdaOe = 1'b0;
  end
  // quarter bit of 8 clocks keeps the bus near 312 kHz
  task automatic q(input int n = 1);
    repeat (n * Q) @(posedge mclk);
  endtask
  // slave may stretch, so wait until the wire is really high
  task automatic up();
    sclOe <= 1'b0;
    for (int i = 0; i < 200 && scl !== 1'b1; i++) @(posedge mclk);
  endtask
  task automatic start();
    @(posedge mclk);
    sdaOe <= 1'b0;
    q();
    up();
    q();
    sdaOe <= 1'b1;
    q();
    sclOe <= 1'b1;
    q();
  endtask
  task automatic stop();
    sdaOe <= 1'b1;
    q();
    up();
    q();
    sdaOe <= 1'b0;
    q(2);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sdaOe <= ~b;
    q();
    up();
    q();
    r = sda;
    q();
    sclOe <= 1'b1;
    q();
  endtask
  task automatic byte_io(input logic [7:0] b, input logic m, output logic [7:0] r,
                         output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], x);
      r[i] = x;
    end
    bit_io(m, x);
    ack = ~x;
  endtask
  // address, index, data in one transfer
  task automatic wr(input logic [7:0] a, input logic [7:0] b1, input logic [7:0] b2,
                    input int n, output logic ack);
    logic [7:0] r;
    start();
    byte_io(a, 1'b1, r, ack);
    if (ack) byte_io(b1, 1'b1, r, ack);
    if (ack && n > 1) byte_io(b2, 1'b1, r, ack);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] d,
                    output logic ack);
    logic k;
    start();
    byte_io({a, 1'b0}, 1'b1, d, ack);
    byte_io(idx, 1'b1, d, k);
    start();
    byte_io({a, 1'b1}, 1'b1, d, k);
    ack = ack & k;
    byte_io(8'hFF, 1'b1, d, k);
    stop();
  endtask
  // two bytes in one read: master acknowledges the first, refuses the second
  task automatic rd2(input logic [6:0] a, input logic [7:0] idx, output logic [15:0] d,
                     output logic ack);
    logic k;
    logic [7:0] r;
    start();
    byte_io({a, 1'b0}, 1'b1, r, ack);
    byte_io(idx, 1'b1, r, k);
    start();
    byte_io({a, 1'b1}, 1'b1, r, k);
    ack = ack & k;
    byte_io(8'hFF, 1'b0, d[15:8], k);
    byte_io(8'hFF, 1'b1, d[7:0], k);
    stop();
  endtask
endmodule

// [tb_top.sv]
/*
  Self-checking bench for the sensor front-end control block.
  Assumes the host model drives the bus and the bench drives pins and comparators.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin failCount++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_top;
  localparam int SD = 4;
  logic mclk, rst, sclOe, sdaOe, hSclOe, hSdaOe, scl, sda, ack;
  logic [1:0] pinIn, pinOut, pinOe, ext;
  logic refOutEn, refInEn, battLow, pumpAtLevel, pumpEnable, pumpBypass, pumpReady;
  logic oscEnable, convDone, sampleTick, readyN;
  logic [2:0] addrSel;
  logic [6:0] me;
  logic [7:0] d, outR, modeR;
  logic [15:0] w;
  logic sclOutW, sdaOutW;
  logic [31:0] seed = 32'h0000003C;
  int failCount = 0;
  int nChecks = 0;
  int run = 0;
  int runMax = 0;
  int cnt;
  assign scl = ~(sclOe | hSclOe);
  assign sda = ~(sdaOe | hSdaOe);
  assign pinIn = (pinOe & pinOut) | (~pinOe & ext);
  saio_top #(.SMP_DIV(SD)) DUT (.mclk(mclk), .rst(rst), .sclIn(scl), .sclOut(sclOutW),
    .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOutW), .sdaOe(sdaOe), .pinIn(pinIn),
    .pinOut(pinOut),
    .pinOe(pinOe), .refOutEn(refOutEn), .refInEn(refInEn), .battLow(battLow),
    .pumpAtLevel(pumpAtLevel), .pumpEnable(pumpEnable), .pumpBypass(pumpBypass),
    .pumpReady(pumpReady), .addrSel(addrSel), .oscEnable(oscEnable),
    .convDone(convDone), .sampleTick(sampleTick), .readyN(readyN));
  saio_host host (.mclk(mclk), .scl(scl), .sda(sda), .sclOe(hSclOe), .sdaOe(hSdaOe));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [1:0] oeExp();
    return outR[5:4] & ~modeR[1:0];
  endfunction
  function automatic logic pumpExp();
    return modeR[3] | (~modeR[2] & battLow);
  endfunction
  // level seen on each pin: own driver where enabled, outside source otherwise
  function automatic logic [1:0] pinExp();
    return (oeExp() & outR[1:0]) | (~oeExp() & ext);
  endfunction
  task automatic reg_wr(input logic [7:0] i, input logic [7:0] v);
    host.wr({me, 1'b0}, i, v, 2, ack);
    `CHK(ack, 1'b1)
  endtask
  task automatic reg_rd(input logic [7:0] i, input logic [7:0] e);
    host.rd(me, i, d, ack);
    `CHK({ack, d}, {1'b1, e})
  endtask
  task automatic port_chk();
    repeat (4) @(posedge mclk);
    #1;
    `CHK(pinOe, oeExp())
    `CHK(pinOut, outR[1:0])
    `CHK({refInEn, refOutEn}, modeR[1:0])
    `CHK({pumpEnable, pumpBypass}, {pumpExp(), ~pumpExp()})
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // longest stretch seen, since holding only happens before an acknowledge
  always @(negedge mclk) begin
    run = sclOe ? run + 1 : 0;
    if (run > runMax) runMax = run;
  end
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // about 60k cycles of traffic expected; allow over half as much again
  initial begin
    repeat (95000) @(posedge mclk);
    failCount++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    ext = 2'b00;
    battLow = 1'b0;
    pumpAtLevel = 1'b0;
    convDone = 1'b0;
    seed = xs(seed);
    addrSel = seed[2:0];
    me = saio_pkg::ADDR_BASE | {4'h0, addrSel};
    outR = saio_pkg::OUT_RST;
    modeR = saio_pkg::MODE_RST;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    port_chk();
    `CHK(oscEnable, 1'b1)
    `CHK({sclOutW, sdaOutW}, 2'b00)
    repeat (40) @(posedge mclk);
    #1;
    `CHK(oscEnable, 1'b0)
    reg_rd(saio_pkg::REG_OUT_A, saio_pkg::OUT_RST);
    reg_rd(saio_pkg::REG_MODE_A, saio_pkg::MODE_RST);
    host.wr({me ^ 7'h01, 1'b0}, saio_pkg::REG_OUT_A, 8'h00, 2, ack);
    `CHK(ack, 1'b0)
    reg_rd(8'h47, 8'h00);
    $display("test boot done");
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      @(posedge mclk);
      ext <= seed[9:8];
      battLow <= k[2];
      outR = seed[7:0] & saio_pkg::OUT_MASK;
      d = {seed[15:12], k[1:0], seed[11:10]};
      modeR = d & saio_pkg::MODE_MASK;
      reg_wr(saio_pkg::REG_OUT_A, seed[7:0]);
      reg_wr(saio_pkg::REG_MODE_A, d);
      port_chk();
      reg_rd(saio_pkg::REG_OUT_A, outR);
      reg_rd(saio_pkg::REG_MODE_A, modeR);
      reg_rd(saio_pkg::REG_IN_A, {6'h00, pinExp()});
    end
    reg_wr(saio_pkg::REG_IN_A, 8'hFF);
    reg_rd(saio_pkg::REG_IN_A, {6'h00, pinExp()});
    host.rd2(me, saio_pkg::REG_OUT_A, w, ack);
    `CHK({ack, w}, {1'b1, outR, 6'h00, pinExp()})
    $display("test port done");
    for (int v = 1; v >= 0; v--) begin
      @(posedge mclk);
      pumpAtLevel <= v[0];
      @(posedge mclk);
      #1;
      `CHK(pumpReady, ~v[0])
      repeat (2) @(posedge mclk);
      #1;
      `CHK(pumpReady, v[0])
    end
    $display("test pump done");
    @(posedge mclk);
    convDone <= 1'b1;
    cnt = 0;
    // a second done strobe lands mid-pulse and must not stretch it
    for (int i = 0; i < 3 * SD; i++) begin
      @(posedge mclk);
      convDone <= (i == 2);
      #1;
      cnt += int'(readyN === 1'b0);
    end
    `CHK(cnt, SD)
    cnt = 0;
    for (int i = 0; i < 8 * SD; i++) begin
      @(posedge mclk);
      #1;
      cnt += int'(sampleTick === 1'b1);
    end
    `CHK(cnt, 8)
    $display("test ready done");
    reg_wr(saio_pkg::REG_OUT_A, 8'h03);
    reg_wr(saio_pkg::REG_MODE_A, 8'h0F);
    host.wr(saio_pkg::GC_ADDR, saio_pkg::GC_RESET, 8'h00, 1, ack);
    `CHK(ack, 1'b1)
    reg_rd(saio_pkg::REG_OUT_A, saio_pkg::OUT_RST);
    reg_rd(saio_pkg::REG_MODE_A, saio_pkg::MODE_RST);
    `CHK(runMax, 2)
    $display("test general call done");
    final_report();
  end
endmodule
